// ---- tws_pkg.sv ----
// package: register map, status codes, link states and timing of the two-wire slave
package tws_pkg;
	// byte offsets on the register bus
	localparam logic [3:0] OFS_CTL  = 4'h0;  // interface_control_reg
	localparam logic [3:0] OFS_STAT = 4'h4;  // bus_condition_code_reg
	localparam logic [3:0] OFS_DATA = 4'h8;  // serial_data_byte_reg
	localparam logic [3:0] OFS_ADR  = 4'hC;  // own_node_address register
	// control field positions
	localparam int CTL_FLAG = 7;  // step_done_flag, write one clears
	localparam int CTL_ACK  = 6;  // ack_enable_bit
	localparam int CTL_BEG  = 5;  // begin_request_bit
	localparam int CTL_HALT = 4;  // halt_request_bit
	localparam int CTL_EN   = 2;  // interface enable
	localparam int ADR_GCE  = 0;  // general_call_enable_bit
	// reset values
	localparam logic [7:0] CTL_RST   = 8'h00;
	localparam logic [7:0] ADR_RST   = 8'h00;
	localparam logic [1:0] PRESC_RST = 2'h0;
	// status codes, prescaler bits zero
	localparam logic [7:0] CODE_SLA_R  = 8'hA8;  // own address read, acked
	localparam logic [7:0] CODE_TX_ACK = 8'hB8;  // byte sent, ack
	localparam logic [7:0] CODE_TX_NAK = 8'hC0;  // byte sent, nack
	localparam logic [7:0] CODE_LAST   = 8'hC8;  // final byte sent, ack
	localparam logic [7:0] CODE_IDLE   = 8'hF8;  // no information
	localparam logic [7:0] CODE_BUSERR = 8'h00;  // illegal start or stop
	localparam logic [7:0] CODE_STSENT = 8'h08;  // start condition sent
	localparam logic [6:0] GC_ADDR     = 7'h00;  // general_call_address
	// timing
	localparam int LCLK_NS        = 15;    // link clock period
	localparam int T_START_HOLD_NS = 4000;  // least start hold time
	localparam int START_HOLD_CYC =
		(T_START_HOLD_NS + LCLK_NS - 1) / LCLK_NS;
	// link side states
	typedef enum logic [3:0] {
		L_IDLE = 4'b0000,  // not addressed, listening
		L_ADDR = 4'b0001,  // shifting in address byte
		L_AACK = 4'b0010,  // driving address ack
		L_TXB  = 4'b0011,  // shifting out data byte
		L_RACK = 4'b0100,  // sampling master ack
		L_HOLD = 4'b0101,  // waiting for software
		L_IGN  = 4'b0110,  // not addressed, ignoring frame
		L_ERR  = 4'b0111,  // bus error, lines released
		L_GEN  = 4'b1000   // generating start
	} tws_link_e;
	// settings carried into the link domain in one handshake
	typedef struct packed {
		logic [6:0] own;   // own_node_address
		logic       gce;   // general call enable
		logic       ack;   // ack enable
		logic       beg;   // begin request at resume
		logic       halt;  // halt request at resume
		logic       en;    // interface enable
		logic       res;   // step done flag cleared
		logic [7:0] data;  // byte to send
	} tws_cfg_s;
endpackage

// ---- tws_sync.sv ----
// two-flop synchroniser for levels and toggles entering a clock domain
`timescale 1ns/1ns
module tws_sync #(
	parameter int         W   = 1,   // bits carried
	parameter logic [W-1:0] RST = '0  // value during reset
) (
	input  wire logic         clk,  // destination clock
	input  wire logic         rst,  // async reset, active high
	input  wire logic [W-1:0] d,    // level from the other domain
	output logic      [W-1:0] q     // synchronised level
);
	logic [W-1:0] meta_ff;  // first stage, read only by q

	// two stages, nothing reads the first but the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= RST;
			q       <= RST;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// ---- tws_top.sv ----
// two-wire slave transmitter end, bus error handling and register slave
`timescale 1ns/1ns
module tws_top
	import tws_pkg::*;
(
	input  wire logic        clk,         // system clock, 10 MHz
	input  wire logic        link_clk,    // link side clock
	input  wire logic        sys_rst,     // async reset, active high
	input  wire logic [3:0]  address,     // byte address
	input  wire logic        read,        // read request
	input  wire logic        write,       // write request
	input  wire logic [31:0] writedata,   // write data
	output logic      [31:0] readdata,    // read data
	output logic             waitrequest, // stall
	input  wire logic        scl_i,       // clock line level
	output logic             scl_o,       // clock line drive value
	output logic             scl_oe_n,    // low while pulling clock
	input  wire logic        sda_i,       // data line level
	output logic             sda_o,       // data line drive value
	output logic             sda_oe_n     // low while pulling data
);
	// system side registers
	logic       flag_ff;          // step_done_flag
	logic       ack_ff;           // ack_enable_bit
	logic       beg_ff;           // begin_request_bit
	logic       halt_ff;          // halt_request_bit
	logic       en_ff;            // enable
	logic [6:0] own_ff;           // own_node_address
	logic       gce_ff;           // general_call_enable_bit
	logic [7:0] data_ff;          // serial_data_byte_reg
	logic [1:0] presc_ff;         // prescaler bits
	logic [7:0] code_ff;          // last reported code
	logic       go_halt_ff;       // halt seen at flag clear
	logic       go_beg_ff;        // begin seen at flag clear
	logic       upd_pend_ff;      // settings changed
	logic       res_pend_ff;      // flag clear not yet sent
	logic       req_tgl_ff;       // handshake request toggle
	tws_cfg_s   snap_ff;          // settings in flight
	logic       ev_q_ff;          // last seen event toggle
	// crossing wires
	logic       ack_s;            // link ack toggle, synced
	logic       ev_s;             // link event toggle, synced
	logic       rq_s;             // request toggle, synced
	logic [1:0] line_s;           // {scl, sda}, synced
	// link side registers
	tws_link_e  st_ff;            // link state
	tws_cfg_s   lcfg_ff;          // settings in use
	logic       rq_q_ff;          // last seen request toggle
	logic       ack_tgl_ff;       // handshake ack toggle
	logic       ev_tgl_ff;        // event toggle
	logic [7:0] ev_code_ff;       // code of last event
	logic [1:0] line_q_ff;        // lines one cycle back
	logic       busy_ff;          // bus between start and stop
	logic [3:0] cnt_ff;           // bit counter
	logic [7:0] sh_ff;            // shift register
	logic       rw_ff;            // direction bit received
	logic       last_ff;          // sending final byte
	logic       stretch_ff;       // hold clock at next fall
	logic       gen_pend_ff;      // start wanted when free
	logic [8:0] gcnt_ff;          // start hold counter

	// bus decode
	wire        acc_wr = write && !waitrequest;
	wire        acc_rd = read && waitrequest;
	wire        wr_ctl = acc_wr && address == OFS_CTL;
	wire        clr    = wr_ctl && writedata[CTL_FLAG];
	wire        ev_new = ev_s ^ ev_q_ff;
	wire        hs_idle = req_tgl_ff == ack_s;
	wire        send   = hs_idle && (upd_pend_ff || res_pend_ff);

	tws_sync #(.W(1), .RST(1'b0)) u_ack_sync (
		.clk (clk),
		.rst (sys_rst),
		.d   (ack_tgl_ff),
		.q   (ack_s)
	);
	tws_sync #(.W(1), .RST(1'b0)) u_ev_sync (
		.clk (clk),
		.rst (sys_rst),
		.d   (ev_tgl_ff),
		.q   (ev_s)
	);

	// bus answer one cycle after the request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
			if (acc_rd) begin
				case (address)
					OFS_CTL:  readdata <= {24'h00_0000, flag_ff, ack_ff, beg_ff,
						halt_ff, 1'b0, en_ff, 2'b00};
					// code only while the flag stands, else the idle code
					OFS_STAT: readdata <= {24'h00_0000, flag_ff ? code_ff[7:3] :
						CODE_IDLE[7:3], 1'b0, presc_ff};
					OFS_DATA: readdata <= {24'h00_0000, data_ff};
					OFS_ADR:  readdata <= {24'h00_0000, own_ff, gce_ff};
					default:  readdata <= 32'h0000_0000;  // unmapped
				endcase
			end
		end
	end

	// software settings
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{ack_ff, beg_ff, halt_ff, en_ff} <= {CTL_RST[CTL_ACK],
				CTL_RST[CTL_BEG], CTL_RST[CTL_HALT], CTL_RST[CTL_EN]};
			{own_ff, gce_ff} <= ADR_RST;
			data_ff  <= 8'h00;
			presc_ff <= PRESC_RST;
		end else if (acc_wr) begin
			case (address)
				OFS_CTL: begin
					ack_ff  <= writedata[CTL_ACK];
					beg_ff  <= writedata[CTL_BEG];
					// halt written with a flag clear drops at once
					halt_ff <= writedata[CTL_HALT] && !writedata[CTL_FLAG];
					en_ff   <= writedata[CTL_EN];
				end
				OFS_STAT: presc_ff <= writedata[1:0];
				OFS_DATA: data_ff <= writedata[7:0];
				OFS_ADR:  {own_ff, gce_ff} <= writedata[7:0];
				default:  ;
			endcase
		end
	end

	// step done flag: a link event wins over a clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flag_ff    <= 1'b0;
			code_ff    <= CODE_IDLE;
			ev_q_ff    <= 1'b0;
			go_halt_ff <= 1'b0;
			go_beg_ff  <= 1'b0;
		end else begin
			ev_q_ff <= ev_s;
			if (ev_new) begin
				flag_ff <= 1'b1;
				code_ff <= ev_code_ff;
			end else if (clr) begin
				flag_ff    <= 1'b0;
				go_halt_ff <= writedata[CTL_HALT];
				go_beg_ff  <= writedata[CTL_BEG];
			end
		end
	end

	// settings travel to the link by a toggle handshake
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			upd_pend_ff <= 1'b1;
			res_pend_ff <= 1'b0;
			req_tgl_ff  <= 1'b0;
			snap_ff     <= '0;
		end else begin
			upd_pend_ff <= (upd_pend_ff && !send) || acc_wr;
			res_pend_ff <= (res_pend_ff && !send) || (clr && flag_ff && !ev_new);
			if (send) begin
				req_tgl_ff <= !req_tgl_ff;
				snap_ff    <= '{own: own_ff, gce: gce_ff, ack: ack_ff,
					beg: go_beg_ff, halt: go_halt_ff, en: en_ff,
					res: res_pend_ff, data: data_ff};
			end
		end
	end

	chk_flag_event: assert property (@(posedge clk) disable iff (sys_rst)
		ev_new |=> flag_ff && code_ff == $past(ev_code_ff))
		else $error("event did not raise the flag");
	chk_halt_self: assert property (@(posedge clk) disable iff (sys_rst)
		(clr && writedata[CTL_HALT]) |=> !halt_ff)
		else $error("halt request not self cleared");
	chk_idle_code: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_rd && address == OFS_STAT && !flag_ff)
		|=> readdata[7:3] == CODE_IDLE[7:3])
		else $error("idle code missing while flag clear");

	// link side
	tws_sync #(.W(1), .RST(1'b0)) u_rq_sync (
		.clk (link_clk),
		.rst (sys_rst),
		.d   (req_tgl_ff),
		.q   (rq_s)
	);
	tws_sync #(.W(2), .RST(2'b11)) u_line_sync (
		.clk (link_clk),
		.rst (sys_rst),
		.d   ({scl_i, sda_i}),
		.q   (line_s)
	);

	wire scl_s     = line_s[1];
	wire sda_s     = line_s[0];
	wire scl_rise  = scl_s && !line_q_ff[1];
	wire scl_fall  = !scl_s && line_q_ff[1];
	wire start_det = scl_s && line_q_ff[1] && line_q_ff[0] && !sda_s;
	wire stop_det  = scl_s && line_q_ff[1] && !line_q_ff[0] && sda_s;
	wire rq_new    = rq_s ^ rq_q_ff;
	wire resume    = rq_new && snap_ff.res;
	wire frame_mid = (st_ff == L_ADDR && cnt_ff != 4'h0) || st_ff == L_AACK ||
		st_ff == L_TXB || st_ff == L_RACK;
	wire own_hit   = lcfg_ff.ack && sh_ff[7:1] == lcfg_ff.own;
	wire gc_hit    = lcfg_ff.ack && lcfg_ff.gce && sh_ff[7:1] == GC_ADDR &&
		!sh_ff[0];

	// line history, bus busy and settings capture
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_q_ff  <= 2'b11;
			busy_ff    <= 1'b0;
			rq_q_ff    <= 1'b0;
			ack_tgl_ff <= 1'b0;
			lcfg_ff    <= '0;
		end else begin
			line_q_ff <= line_s;
			busy_ff   <= start_det || (busy_ff && !stop_det);
			rq_q_ff   <= rq_s;
			if (rq_new) begin
				lcfg_ff    <= snap_ff;
				ack_tgl_ff <= rq_s;
			end
		end
	end

	// link state machine, line drivers and events
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff       <= L_IDLE;
			cnt_ff      <= 4'h0;
			sh_ff       <= 8'h00;
			rw_ff       <= 1'b0;
			last_ff     <= 1'b0;
			stretch_ff  <= 1'b0;
			gen_pend_ff <= 1'b0;
			gcnt_ff     <= 9'h000;
			ev_tgl_ff   <= 1'b0;
			ev_code_ff  <= CODE_IDLE;
			sda_oe_n    <= 1'b1;
			scl_oe_n    <= 1'b1;
		end else if (!lcfg_ff.en) begin
			// disabled: stand off the bus
			st_ff       <= L_IDLE;
			gen_pend_ff <= 1'b0;
			sda_oe_n    <= 1'b1;
			scl_oe_n    <= 1'b1;
		end else if (frame_mid && (start_det || stop_det)) begin
			st_ff      <= L_ERR;
			ev_code_ff <= CODE_BUSERR;
			ev_tgl_ff  <= !ev_tgl_ff;
			sda_oe_n   <= 1'b1;
			scl_oe_n   <= 1'b1;
		end else begin
			case (st_ff)
				L_IDLE, L_IGN: begin
					// unaddressed: data line released, except when L_IDLE pulls it low to generate a start
					sda_oe_n <= 1'b1;
					if (st_ff == L_IDLE && gen_pend_ff && !busy_ff) begin
						st_ff    <= L_GEN;
						sda_oe_n <= 1'b0;
						gcnt_ff  <= 9'h000;
					end else if (start_det) begin
						st_ff  <= L_ADDR;
						cnt_ff <= 4'h0;
					end else if (stop_det) begin
						st_ff <= L_IDLE;
					end
				end
				L_GEN: begin
					// hold the start, then keep the clock low
					gcnt_ff <= gcnt_ff + 9'h001;
					if (gcnt_ff == 9'(START_HOLD_CYC - 1)) begin
						scl_oe_n    <= 1'b0;
						gen_pend_ff <= 1'b0;
						st_ff       <= L_HOLD;
						ev_code_ff  <= CODE_STSENT;
						ev_tgl_ff   <= !ev_tgl_ff;
					end
				end
				L_ADDR: begin
					if (start_det) begin
						cnt_ff <= 4'h0;
					end else if (stop_det) begin
						st_ff <= L_IDLE;
					end else if (scl_rise) begin
						sh_ff  <= {sh_ff[6:0], sda_s};
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == 4'h8) begin
						if ((own_hit && sh_ff[0]) || own_hit || gc_hit) begin
							st_ff    <= L_AACK;
							sda_oe_n <= 1'b0;
							rw_ff    <= sh_ff[0];
						end else begin
							st_ff <= L_IGN;
						end
					end
				end
				L_AACK: begin
					if (scl_fall) begin
						sda_oe_n <= 1'b1;
						if (rw_ff) begin
							st_ff      <= L_HOLD;
							scl_oe_n   <= 1'b0;
							stretch_ff <= 1'b0;
							ev_code_ff <= CODE_SLA_R;
							ev_tgl_ff  <= !ev_tgl_ff;
						end else begin
							st_ff <= L_IGN;
						end
					end
				end
				L_TXB: begin
					if (scl_rise) begin
						cnt_ff <= cnt_ff + 4'h1;
					end else if (scl_fall) begin
						if (cnt_ff == 4'h8) begin
							sda_oe_n <= 1'b1;
							st_ff    <= L_RACK;
						end else begin
							sda_oe_n <= sh_ff[6];
							sh_ff    <= {sh_ff[6:0], 1'b0};
						end
					end
				end
				L_RACK: begin
					if (scl_rise) begin
						st_ff      <= L_HOLD;
						stretch_ff <= !sda_s && !last_ff;
						ev_tgl_ff  <= !ev_tgl_ff;
						if (sda_s) begin
							ev_code_ff <= CODE_TX_NAK;
						end else if (last_ff) begin
							ev_code_ff <= CODE_LAST;
						end else begin
							ev_code_ff <= CODE_TX_ACK;
						end
					end
				end
				L_HOLD: begin
					// with the flag clear the link just carries on
					if (stretch_ff && scl_fall) begin
						scl_oe_n <= 1'b0;
					end
					if (resume) begin
						scl_oe_n   <= 1'b1;
						stretch_ff <= 1'b0;
						if (ev_code_ff == CODE_SLA_R || ev_code_ff == CODE_TX_ACK) begin
							st_ff    <= L_TXB;
							sh_ff    <= snap_ff.data;
							sda_oe_n <= snap_ff.data[7];
							cnt_ff   <= 4'h0;
							last_ff  <= !snap_ff.ack;
						end else begin
							// end of transmit: unaddressed, start if asked
							st_ff       <= L_IDLE;
							sda_oe_n    <= 1'b1;
							gen_pend_ff <= snap_ff.beg;
						end
					end
				end
				L_ERR: begin
					// recovery only resets state, lines stay released
					sda_oe_n <= 1'b1;
					scl_oe_n <= 1'b1;
					if (resume && snap_ff.halt) begin
						st_ff <= L_IDLE;
					end
				end
				default: st_ff <= L_IDLE;
			endcase
		end
	end

	// constant drive values, the enables do the work
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end
	end

	chk_nack_code: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_RACK && scl_rise && sda_s && lcfg_ff.en && !start_det &&
		!stop_det) |=> ev_code_ff == CODE_TX_NAK && st_ff == L_HOLD)
		else $error("nack after byte did not give its code");
	chk_last_ack: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_RACK && scl_rise && !sda_s && last_ff && lcfg_ff.en &&
		!start_det && !stop_det) |=> ev_code_ff == CODE_LAST)
		else $error("ack after final byte did not give its code");
	chk_err_detect: assert property (@(posedge link_clk) disable iff (sys_rst)
		(frame_mid && (start_det || stop_det) && lcfg_ff.en)
		|=> st_ff == L_ERR && ev_code_ff == CODE_BUSERR &&
		ev_tgl_ff != $past(ev_tgl_ff))
		else $error("bus error not caught");
	chk_err_release: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_ERR) ##1 (st_ff == L_ERR) |-> sda_oe_n && scl_oe_n)
		else $error("line driven during bus error");
	chk_unaddr_release: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_IGN) [*2] |-> sda_oe_n)
		else $error("data line driven while not addressed");
	chk_no_recog: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_ADDR && scl_fall && cnt_ff == 4'h8 && !lcfg_ff.ack &&
		lcfg_ff.en && !start_det && !stop_det) |=> st_ff == L_IGN)
		else $error("address recognised with ack disabled");
	chk_clock_hold: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_HOLD && stretch_ff && scl_fall && !resume && lcfg_ff.en)
		|=> !scl_oe_n [*2])
		else $error("clock not held while flag set");
	chk_recover_idle: assert property (@(posedge link_clk) disable iff (sys_rst)
		(st_ff == L_ERR && resume && snap_ff.halt && lcfg_ff.en &&
		!frame_mid) |=> st_ff == L_IDLE)
		else $error("recovery did not return to unaddressed mode");
endmodule

// ---- tws_master_model.sv ----
// two-wire bus master model, its clock stands still between frames
`timescale 1ns/1ns
module tws_master_model (
	input  wire logic link_clk, // link clock
	input  wire logic scl_i,    // clock line level
	input  wire logic sda_i,    // data line level
	output logic      scl_oe_n, // low while pulling clock
	output logic      sda_oe_n  // low while pulling data
);
	// both lines released at start
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end
	// one half period of the bus clock, longer than the sync delay
	task automatic half();
		repeat (24) @(posedge link_clk);
	endtask
	// set both pulls just after a link edge, then hold a half period
	task automatic put(input logic c, input logic s);
		@(posedge link_clk);
		scl_oe_n <= c;
		sda_oe_n <= s;
		half();
	endtask
	// start from an idle bus
	task automatic start();
		put(1'b1, 1'b0);
		put(1'b0, 1'b0);
	endtask
	// repeated start, the bus is never given up in between
	task automatic rstart();
		put(1'b0, 1'b1);
		put(1'b1, 1'b1);
		start();
	endtask
	// stop condition, leaves both lines released
	task automatic stop();
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask
	// one bit: v of 1 releases data; waits out clock stretching
	task automatic xbit(input logic v, output logic r);
		int n;
		put(1'b0, v);
		scl_oe_n <= 1'b1;
		n = 0;
		// a slave may hold the clock low, bounded wait
		while (scl_i !== 1'b1 && n < 9000) begin
			@(posedge link_clk);
			n++;
		end
		half();
		r = sda_i;
		put(1'b0, v);
	endtask
	// eight bits, most significant first
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
	endtask
endmodule

// ---- tws_top_test.sv ----
// self-checking bench for slave transmit end, idle code and bus errors
`timescale 1ns/1ns
module tws_top_test
	import tws_pkg::*;
;
	logic        clk, link_clk, sys_rst;  // clocks and reset
	logic        read, write, waitrequest; // bus strobes
	logic [3:0]  address;                  // bus address
	logic [31:0] writedata, readdata, d;   // bus data, read result
	logic        scl_o, sda_o;             // drive values, held low
	logic        scl_oe_n, sda_oe_n;       // device pulls
	logic        m_scl_oe_n, m_sda_oe_n;   // master pulls
	wire         scl = scl_oe_n & m_scl_oe_n; // pulled-up clock line
	wire         sda = sda_oe_n & m_sda_oe_n; // pulled-up data line
	int          num_errors, check_count, cyc; // counters
	logic [7:0]  q;                        // byte seen by master
	logic        k;                        // ack bit seen by master
	tws_top dut (.clk, .link_clk, .sys_rst, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda),
		.sda_o, .sda_oe_n);
	tws_master_model m (.link_clk, .scl_i(scl), .sda_i(sda), .scl_oe_n(m_scl_oe_n),
		.sda_oe_n(m_sda_oe_n));
	always #50 clk = ~clk;
	// link clock of 15 ns, offset from the system clock
	initial begin
		link_clk = 1'b0;
		#4;
		forever begin
			#7 link_clk = 1'b1;
			#8 link_clk = 1'b0;
		end
	end
	// cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, s);
		end
	endtask
	// one bus access, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, v};
		write <= w;
		read <= ~w;
		// waitrequest and read data are taken at the same rising edge
		do @(posedge clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// poll the flag, then compare the masked status code
	task automatic flag(input logic [7:0] code);
		d = '0;
		for (int n = 0; n < 200 && d[CTL_FLAG] !== 1'b1; n++) bus(0, OFS_CTL, 8'h00);
		bus(0, OFS_STAT, 8'h00);
		chk(d & 32'h0000_00F8, 32'(code), "status code");
	endtask
	// start or repeated start, address byte, ack bit
	task automatic adr(input logic [7:0] a, input logic rs);
		if (rs)
			m.rstart();
		else
			m.start();
		m.xbyte(a, q);
		m.xbit(1'b1, k);
	endtask
	// final byte with ack enable low, master answers ma
	task automatic last(input logic [7:0] v, input logic ma, input logic [7:0] code);
		bus(1, OFS_DATA, v);
		bus(1, OFS_CTL, 8'h84);
		m.xbyte(8'hFF, q);
		chk(32'(q), 32'(v), "byte sent");
		m.xbit(ma, k);
		flag(code);
	endtask
	// reset values, idle code with prescaler set, unmapped read
	task automatic t_idle();
		bus(0, OFS_CTL, 8'h00);
		chk(d, 32'h0, "control reset");
		bus(1, OFS_STAT, 8'h03);
		bus(0, OFS_STAT, 8'h00);
		chk(d, 32'hFB, "idle status");
		bus(0, 4'h2, 8'h00);
		chk(d, 32'h0, "unmapped read");
		chk(32'({scl_o, sda_o}), 32'h0, "drive values low");
		bus(1, OFS_ADR, 8'hA0);
		bus(0, OFS_ADR, 8'h00);
		chk(d, 32'hA0, "address readback");
		bus(1, OFS_DATA, 8'h69);
		bus(0, OFS_DATA, 8'h00);
		chk(d, 32'h69, "data readback");
		bus(1, OFS_CTL, 8'h44);
		repeat (10) @(posedge clk);
	endtask
	// nack ends the transfer, then the slave ignores everything
	task automatic t_nack();
		adr(8'hA1, 0);
		chk(32'(k), 32'h0, "read address acked");
		flag(CODE_SLA_R);
		chk(32'(scl_oe_n), 32'h0, "clock held");
		last(8'hC3, 1, CODE_TX_NAK);
		bus(1, OFS_CTL, 8'h84);
		m.xbyte(8'hFF, q);
		chk(32'(q), 32'hFF, "data released");
		m.xbit(1'b1, k);
		m.stop();
		adr(8'hA1, 0);
		chk(32'(k), 32'h1, "own address ignored");
		m.stop();
	endtask
	// repeated start into a read, ack after the final byte
	task automatic t_last();
		bus(1, OFS_CTL, 8'hC4);
		adr(8'h00, 0);
		chk(32'(k), 32'h1, "general call off");
		m.stop();
		adr(8'hA0, 0);
		adr(8'hA1, 1);
		chk(32'(k), 32'h0, "read after repeated start");
		flag(CODE_SLA_R);
		// one byte with ack enable high, master acks, clock is stretched
		bus(1, OFS_DATA, 8'h96);
		bus(1, OFS_CTL, 8'hC4);
		m.xbyte(8'hFF, q);
		chk(32'(q), 32'h96, "byte before last");
		m.xbit(1'b0, k);
		flag(CODE_TX_ACK);
		chk(32'(scl_oe_n), 32'h0, "clock held after ack");
		last(8'h5A, 0, CODE_LAST);
		bus(1, OFS_CTL, 8'hC4);
		m.stop();
		adr(8'hA1, 0);
		chk(32'(k), 32'h0, "own address seen");
		flag(CODE_SLA_R);
		last(8'h3C, 1, CODE_TX_NAK);
		bus(1, OFS_CTL, 8'hC4);
		m.stop();
		bus(1, OFS_ADR, 8'hA1);
		adr(8'h00, 0);
		chk(32'(k), 32'h0, "general call on");
		m.stop();
	endtask
	// begin request at resume waits for a free bus
	task automatic t_beg();
		adr(8'hA1, 0);
		flag(CODE_SLA_R);
		last(8'h77, 1, CODE_TX_NAK);
		bus(1, OFS_CTL, 8'hA4);
		bus(0, OFS_CTL, 8'h00);
		chk(32'(d[CTL_FLAG]), 32'h0, "bus still busy");
		m.stop();
		flag(CODE_STSENT);
		chk(32'({scl_oe_n, sda}), 32'h0, "start driven");
		bus(1, OFS_CTL, 8'h84);
		repeat (20) @(posedge clk);
		chk(32'({scl_oe_n, sda_oe_n}), 32'h3, "lines free");
	endtask
	// stop inside an address byte, then recovery
	task automatic t_err();
		bus(1, OFS_CTL, 8'hC4);
		m.start();
		repeat (3) m.xbit(1'b1, k);
		m.stop();
		flag(CODE_BUSERR);
		bus(1, OFS_CTL, 8'hD4);
		bus(0, OFS_CTL, 8'h00);
		chk(d, 32'h44, "halt self clears");
		repeat (20) @(posedge link_clk);
		chk(32'({scl, sda, scl_oe_n, sda_oe_n}), 32'hF, "no stop sent");
		bus(0, OFS_STAT, 8'h00);
		chk(d, 32'hFB, "idle after recovery");
		adr(8'hA1, 0);
		chk(32'(k), 32'h0, "listening again");
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{read, write, address, writedata} = '0;
		{num_errors, check_count, cyc} = '0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (10) @(posedge clk);
		t_idle();
		t_nack();
		t_last();
		t_beg();
		t_err();
		test_done();
	end
endmodule
